/* File: rtl/anc_autoneg.sv */
// anc_autoneg: strap capture, management registers and negotiation control.
// assumes straps and receiver link levels arrive from pins (synchronised here),
// and received code words come from a page decoder on core_clk.
`timescale 1ns/10ps
`default_nettype none

module anc_autoneg #(
  parameter int unsigned BREAK_CYC  = anc_pkg::BREAK_CYC,
  parameter int unsigned AN_MAX_CYC = anc_pkg::AN_MAX_CYC,
  parameter int unsigned XOVER_CYC  = anc_pkg::XOVER_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        adv_strap_low,
  input  wire logic        adv_strap_high,
  input  wire logic        led_mode_strap,
  input  wire logic        crossover_enable_strap,
  input  wire logic        link_10_good,
  input  wire logic        link_100_good,
  input  wire logic        page_rx_valid,
  input  wire logic [15:0] page_rx_word,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        mgmt_rd,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic             flp_send,
  output logic      [15:0] flp_word,
  output logic             tx_quiet,
  output logic             link_up,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             an_done,
  output logic             crossover,
  output logic             led_link_only
);

  typedef struct packed {
    anc_pkg::anc_state_e st;
    logic [3:0]          strap_s1;
    logic [3:0]          strap_s2;
    logic [1:0]          link_s1;
    logic [1:0]          link_s2;
    logic [1:0]          strap_cnt;
    logic                strap_done;
    logic [anc_pkg::TW-1:0] timer;
    logic [anc_pkg::TW-1:0] slot;
    logic [15:0]         bmc;
    logic [15:0]         adv;
    logic [15:0]         lp;
    logic [15:0]         pcm;
    logic                pdf;
    logic                page_rx;
    logic                lp_an_able;
    logic                page_seen;
    logic                complete;
    logic                res_speed;
    logic                res_full;
    logic                link;
    logic                xover;
    logic [7:0]          lfsr;
    logic [15:0]         rdata;
    logic                rvalid;
  } anc_state_s;

  anc_state_s s;
  anc_state_s next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // straps index {high, low} -> advertisement bits 8:5
  function automatic logic [3:0] anc_strap_adv(input logic [1:0] st);
    case (st)
      2'h0:    anc_strap_adv = 4'h3;
      2'h1:    anc_strap_adv = 4'hc;
      2'h2:    anc_strap_adv = 4'h5;
      default: anc_strap_adv = 4'hf;
    endcase
  endfunction : anc_strap_adv

  // returns {found, speed_100, full}
  function automatic logic [2:0] anc_resolve(input logic [3:0] common);
    if (common[3])
      anc_resolve = 3'h7;
    else if (common[2])
      anc_resolve = 3'h6;
    else if (common[1])
      anc_resolve = 3'h5;
    else if (common[0])
      anc_resolve = 3'h4;
    else
      anc_resolve = 3'h0;
  endfunction : anc_resolve

  logic [15:0] bms_word;
  logic [15:0] exp_word;
  logic [15:0] sum_word;
  logic [2:0]  res;
  logic        l10;
  logic        l100;
  logic        res_link;
  logic        restart_req;
  logic        wr_bmc;

  always_comb begin
    l10  = s.link_s2[0];
    l100 = s.link_s2[1];
    res_link = s.res_speed ? l100 : l10;
    res = anc_resolve(s.adv[anc_pkg::ADV_100FD:anc_pkg::ADV_10HD] &
                      s.lp[anc_pkg::ADV_100FD:anc_pkg::ADV_10HD]);
    bms_word = anc_pkg::BMS_FIXED;
    bms_word[5] = s.complete;
    bms_word[4] = s.lp[anc_pkg::LP_RFAULT] & s.lp_an_able;
    bms_word[2] = s.link;
    exp_word = {11'h000, s.pdf, s.lp[anc_pkg::LP_NP] & s.lp_an_able,
                1'b0, s.page_rx, s.lp_an_able};
    sum_word = {11'h000, s.complete, 1'b0, s.res_full, ~s.res_speed, s.link};
    wr_bmc = mgmt_wr && (mgmt_addr == anc_pkg::OFS_BASIC_MODE_CONTROL);
    restart_req = wr_bmc && mgmt_wdata[anc_pkg::BMC_AN_EN] &&
                  (mgmt_wdata[anc_pkg::BMC_RESTART] || !s.bmc[anc_pkg::BMC_AN_EN]);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.strap_s1 = {adv_strap_high, adv_strap_low, led_mode_strap,
                       crossover_enable_strap};
    next_s.strap_s2 = s.strap_s1;
    next_s.link_s1  = {link_100_good, link_10_good};
    next_s.link_s2  = s.link_s1;
    next_s.lfsr     = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
    next_s.rvalid   = 1'b0;

    // straps are caught once the synchronisers have settled after release
    if (!s.strap_done) begin
      next_s.strap_cnt = s.strap_cnt + 2'h1;
      if (s.strap_cnt == anc_pkg::STRAP_SETTLE) begin
        next_s.strap_done = 1'b1;
        next_s.adv[anc_pkg::ADV_100FD:anc_pkg::ADV_10HD] =
          anc_strap_adv(s.strap_s2[3:2]);
        next_s.bmc[anc_pkg::BMC_SPEED] =
          s.strap_s2[3] | s.strap_s2[2];
        next_s.bmc[anc_pkg::BMC_DUPLEX] = ~(s.strap_s2[3] ^ s.strap_s2[2]) |
                                          ~s.strap_s2[3];
        next_s.pcm[anc_pkg::PCM_LED]    = s.strap_s2[1];
        next_s.pcm[anc_pkg::PCM_AUTO_X] = s.strap_s2[0];
      end
    end

    // ----------------------------------------------------------------
    // management writes override strap values until the next reset
    // ----------------------------------------------------------------
    if (mgmt_wr) begin
      case (mgmt_addr)
        anc_pkg::OFS_BASIC_MODE_CONTROL:
          next_s.bmc = mgmt_wdata & anc_pkg::BMC_WMASK;
        anc_pkg::OFS_ABILITY_ADVERTISEMENT:
          next_s.adv = mgmt_wdata;
        anc_pkg::OFS_PHY_CONTROL_MISC:
          next_s.pcm = mgmt_wdata;
        default: ;
      endcase
    end

    if (mgmt_rd) begin
      next_s.rvalid = 1'b1;
      case (mgmt_addr)
        anc_pkg::OFS_BASIC_MODE_CONTROL:    next_s.rdata = s.bmc;
        anc_pkg::OFS_BASIC_MODE_STATUS:     next_s.rdata = bms_word;
        anc_pkg::OFS_ABILITY_ADVERTISEMENT: next_s.rdata = s.adv;
        anc_pkg::OFS_PARTNER_ABILITY:       next_s.rdata = s.lp;
        anc_pkg::OFS_NEGOTIATION_EXPANSION: next_s.rdata = exp_word;
        anc_pkg::OFS_PHY_STATUS_SUMMARY:    next_s.rdata = sum_word;
        anc_pkg::OFS_PHY_CONTROL_MISC:      next_s.rdata = s.pcm;
        default:                            next_s.rdata = 16'h0000;
      endcase
      // page received and detect fault clear on read; a new event below wins
      if (mgmt_addr == anc_pkg::OFS_NEGOTIATION_EXPANSION) begin
        next_s.page_rx = 1'b0;
        next_s.pdf     = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // negotiation state machine
    // ----------------------------------------------------------------
    case (s.st)
      anc_pkg::ST_FORCED: begin
        next_s.res_speed = s.bmc[anc_pkg::BMC_SPEED];
        next_s.res_full  = s.bmc[anc_pkg::BMC_DUPLEX];
        next_s.link      = s.bmc[anc_pkg::BMC_SPEED] ? l100 : l10;
        next_s.complete  = 1'b0;
        if (s.strap_done && s.bmc[anc_pkg::BMC_AN_EN]) begin
          next_s.st        = anc_pkg::ST_ABILITY;
          next_s.timer     = '0;
          next_s.page_seen = 1'b0;
          next_s.link      = 1'b0;
        end
      end
      anc_pkg::ST_BREAK: begin
        next_s.timer = s.timer + anc_pkg::TW'(1);
        if (s.timer >= anc_pkg::TW'(BREAK_CYC - 1)) begin
          next_s.st    = anc_pkg::ST_ABILITY;
          next_s.timer = '0;
        end
      end
      anc_pkg::ST_ABILITY: begin
        next_s.timer = s.timer + anc_pkg::TW'(1);
        if (page_rx_valid) begin
          next_s.lp         = page_rx_word;
          next_s.page_rx    = 1'b1;
          next_s.lp_an_able = 1'b1;
          next_s.page_seen  = 1'b1;
        end
        if (s.page_seen) begin
          if (res[2] && (res[1] ? l100 : l10)) begin
            next_s.st        = anc_pkg::ST_COMPLETE;
            next_s.res_speed = res[1];
            next_s.res_full  = res[0];
            next_s.complete  = 1'b1;
            next_s.link      = 1'b1;
          end
        end else if (l10 ^ l100) begin
          // partner sends link signals but no code words: parallel detect
          next_s.st         = anc_pkg::ST_COMPLETE;
          next_s.lp         = l100 ? anc_pkg::LP_PD_100 : anc_pkg::LP_PD_10;
          next_s.lp_an_able = 1'b0;
          next_s.res_speed  = l100;
          next_s.res_full   = 1'b0;
          next_s.complete   = 1'b1;
          next_s.link       = 1'b1;
        end else if (l10 && l100) begin
          next_s.pdf = 1'b1;
        end
        // no result in the allowed time: start over through the break timer
        if (next_s.st == anc_pkg::ST_ABILITY &&
            s.timer >= anc_pkg::TW'(AN_MAX_CYC - 1)) begin
          next_s.st        = anc_pkg::ST_BREAK;
          next_s.timer     = '0;
          next_s.page_seen = 1'b0;
        end
      end
      anc_pkg::ST_COMPLETE: begin
        if (!res_link) begin
          next_s.st        = anc_pkg::ST_ABILITY;
          next_s.timer     = '0;
          next_s.complete  = 1'b0;
          next_s.link      = 1'b0;
          next_s.page_seen = 1'b0;
        end
      end
      default: next_s.st = anc_pkg::ST_FORCED;
    endcase

    if (!next_s.bmc[anc_pkg::BMC_AN_EN] && s.strap_done) begin
      next_s.st = anc_pkg::ST_FORCED;
    end else if (restart_req) begin
      next_s.st        = anc_pkg::ST_BREAK;
      next_s.timer     = '0;
      next_s.complete  = 1'b0;
      next_s.link      = 1'b0;
      next_s.page_seen = 1'b0;
    end

    // ----------------------------------------------------------------
    // crossover: random dwell while hunting, frozen once the link is up
    // ----------------------------------------------------------------
    next_s.slot = s.slot + anc_pkg::TW'(1);
    if (s.pcm[anc_pkg::PCM_FORCE_X]) begin
      next_s.xover = 1'b1;
    end else if (!s.pcm[anc_pkg::PCM_AUTO_X] || !s.bmc[anc_pkg::BMC_AN_EN]) begin
      next_s.xover = 1'b0;
    end else if (s.slot >= anc_pkg::TW'(XOVER_CYC - 1)) begin
      next_s.slot = '0;
      if (s.st != anc_pkg::ST_COMPLETE)
        next_s.xover = s.lfsr[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s            <= '0;
      s.st         <= anc_pkg::ST_FORCED;
      s.bmc        <= anc_pkg::BMC_RESET;
      s.adv        <= anc_pkg::ADV_RESET;
      s.pcm        <= anc_pkg::PCM_RESET;
      s.lfsr       <= 8'h01;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mgmt_rdata    = s.rdata;
  assign mgmt_rvalid   = s.rvalid;
  assign flp_send      = (s.st == anc_pkg::ST_ABILITY);
  assign flp_word      = s.adv;
  assign tx_quiet      = (s.st == anc_pkg::ST_BREAK);
  assign link_up       = s.link;
  assign speed_100     = s.res_speed;
  assign full_duplex   = s.res_full;
  assign an_done       = s.complete;
  assign crossover     = s.xover;
  assign led_link_only = s.pcm[anc_pkg::PCM_LED];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  break_quiet_a: assert property (
    (s.st == anc_pkg::ST_BREAK) |-> (tx_quiet && !flp_send))
    else $error("pulses sent during break hold-off");

  break_hold_a: assert property (
    (s.st == anc_pkg::ST_BREAK && s.timer < anc_pkg::TW'(BREAK_CYC - 1) &&
     !mgmt_wr) |=> (s.st == anc_pkg::ST_BREAK))
    else $error("break hold-off ended early");

  restart_go_a: assert property (
    (restart_req && !rst) |=> (s.st == anc_pkg::ST_BREAK) && !an_done)
    else $error("restart did not start break hold-off");

  pd_word_a: assert property (
    ($rose(an_done) && !s.lp_an_able) |->
      (s.lp == anc_pkg::LP_PD_100 && speed_100) ||
      (s.lp == anc_pkg::LP_PD_10 && !speed_100))
    else $error("parallel detect partner word wrong");

  prio_pick_a: assert property (
    ($rose(an_done) && s.lp_an_able && s.adv[8] && s.lp[8]) |->
      (speed_100 && full_duplex))
    else $error("highest common ability not chosen");

  forced_mode_a: assert property (
    (s.st == anc_pkg::ST_FORCED && s.strap_done && !mgmt_wr)[*2] |->
      (speed_100 == s.bmc[anc_pkg::BMC_SPEED]) &&
      (full_duplex == s.bmc[anc_pkg::BMC_DUPLEX]))
    else $error("forced speed or duplex not applied");

  status_fixed_a: assert property (
    (mgmt_rd && mgmt_addr == anc_pkg::OFS_BASIC_MODE_STATUS) |=>
      (mgmt_rvalid && !mgmt_rdata[15] && mgmt_rdata[14:11] == 4'hf && mgmt_rdata[3]))
    else $error("fixed ability bits wrong");

  link_loss_a: assert property (
    (s.st == anc_pkg::ST_COMPLETE && !res_link && !mgmt_wr) |=>
      (s.st == anc_pkg::ST_ABILITY) && !an_done)
    else $error("negotiation not resumed after link loss");

  pd_fault_a: assert property (
    (s.st == anc_pkg::ST_ABILITY && !s.page_seen && l10 && l100) |=> s.pdf)
    else $error("parallel detect fault not flagged");

  force_xover_a: assert property (
    s.pcm[anc_pkg::PCM_FORCE_X] |=> crossover)
    else $error("forced crossover not applied");

  strap_load_a: assert property (
    $rose(s.strap_done) |->
      (s.adv[8:5] == anc_strap_adv($past(s.strap_s2[3:2])) || $past(mgmt_wr)))
    else $error("advertisement straps not loaded");

endmodule : anc_autoneg

`default_nettype wire

/* File: rtl/anc_pkg.sv */
// anc_pkg: constants for the negotiation and strap configuration block.
// assumes a 10 MHz core clock; register offsets are management register numbers.
package anc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_BASIC_MODE_CONTROL    = 5'h00;
  localparam logic [4:0] OFS_BASIC_MODE_STATUS     = 5'h01;
  localparam logic [4:0] OFS_ABILITY_ADVERTISEMENT = 5'h04;
  localparam logic [4:0] OFS_PARTNER_ABILITY       = 5'h05;
  localparam logic [4:0] OFS_NEGOTIATION_EXPANSION = 5'h06;
  localparam logic [4:0] OFS_PHY_STATUS_SUMMARY    = 5'h10;
  localparam logic [4:0] OFS_PHY_CONTROL_MISC      = 5'h19;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BMC_SPEED   = 13;
  localparam int BMC_AN_EN   = 12;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX  = 8;
  localparam int ADV_100FD   = 8;
  localparam int ADV_100HD   = 7;
  localparam int ADV_10FD    = 6;
  localparam int ADV_10HD    = 5;
  localparam int LP_NP       = 15;
  localparam int LP_RFAULT   = 13;
  localparam int PCM_AUTO_X  = 15;
  localparam int PCM_FORCE_X = 14;
  localparam int PCM_LED     = 5;

  // ----------------------------------------------------------------
  // reset values and fixed words
  // ----------------------------------------------------------------
  localparam logic [15:0] BMC_WMASK     = 16'h3100;
  localparam logic [15:0] BMC_RESET     = 16'h1000;
  localparam logic [15:0] ADV_RESET     = 16'h01e1;
  localparam logic [15:0] PCM_RESET     = 16'h8020;
  localparam logic [15:0] BMS_FIXED     = 16'h7849;
  localparam logic [4:0]  SELECTOR_8023 = 5'h01;
  localparam logic [15:0] LP_PD_100     = 16'h0081;
  localparam logic [15:0] LP_PD_10      = 16'h0021;
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int BREAK_MS     = 1500;
  localparam int AN_MAX_MS    = 3000;
  localparam int XOVER_SLOT_US = 60000;
  localparam int BREAK_CYC    = BREAK_MS * (CLK_HZ / 1000);
  localparam int AN_MAX_CYC   = AN_MAX_MS * (CLK_HZ / 1000);
  localparam int XOVER_CYC    = XOVER_SLOT_US * (CLK_HZ / 1_000_000);
  localparam int TW           = 26;

  typedef enum logic [3:0] {
    ST_FORCED   = 4'b0001,
    ST_BREAK    = 4'b0010,
    ST_ABILITY  = 4'b0100,
    ST_COMPLETE = 4'b1000
  } anc_state_e;

endpackage : anc_pkg

/* File: verification/anc_autoneg_tb.sv */
// anc_autoneg_tb: self-checking bench for the negotiation and strap block.
// assumes short timer parameters; stimulus lands 1 ns after each rising edge.
`timescale 1ns/10ps
`default_nettype none

module anc_autoneg_tb;
  localparam int BK = 50;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  adv_code = 2'h3;
  logic        led_s = 1'b1;
  logic        xo_s = 1'b1;
  logic        page_en = 1'b0;
  logic        sig_10 = 1'b0;
  logic        sig_100 = 1'b0;
  logic [15:0] page_word = 16'h0000;
  logic [4:0]  mgmt_addr = 5'h00;
  logic        mgmt_wr = 1'b0;
  logic        mgmt_rd = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata, flp_word, page_rx_word, rv;
  logic        mgmt_rvalid, flp_send, tx_quiet, link_up, speed_100, full_duplex, an_done;
  logic        crossover, led_link_only, link_10_good, link_100_good, page_rx_valid;
  int          compares = 0;
  int          n_mismatch = 0;

  always #50 core_clk = ~core_clk;

  anc_autoneg #(.BREAK_CYC(BK), .AN_MAX_CYC(400), .XOVER_CYC(20)) anc_autoneg_i (
    .core_clk(core_clk), .rst(rst), .adv_strap_low(adv_code[0]),
    .adv_strap_high(adv_code[1]), .led_mode_strap(led_s), .crossover_enable_strap(xo_s),
    .link_10_good(link_10_good), .link_100_good(link_100_good),
    .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .flp_send(flp_send), .flp_word(flp_word),
    .tx_quiet(tx_quiet), .link_up(link_up), .speed_100(speed_100),
    .full_duplex(full_duplex), .an_done(an_done), .crossover(crossover),
    .led_link_only(led_link_only));

  anc_link_partner anc_link_partner_i (
    .core_clk(core_clk), .flp_send(flp_send), .page_en(page_en), .page_word(page_word),
    .sig_10(sig_10), .sig_100(sig_100), .link_10_good(link_10_good),
    .link_100_good(link_100_good), .page_rx_valid(page_rx_valid),
    .page_rx_word(page_rx_word));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chkb
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    cyc(1);
    mgmt_wr = 1'b0;
  endtask : wr
  // the answer stands for one cycle only, so it is taken right here
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    cyc(1);
    mgmt_rd = 1'b0;
    chkb(mgmt_rvalid, 1'b1);
    d = mgmt_rdata;
    // one idle edge so a following read never re-raises the strobe in this time step
    cyc(1);
  endtask : rd
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chkb(s, 1'b1);
  endtask : wait_hi
  task automatic do_reset(input logic [1:0] c, input logic l, input logic x);
    {adv_code, led_s, xo_s, rst} = {c, l, x, 1'b1};
    {sig_10, sig_100, page_en} = 3'h0;
    cyc(20);
    rst = 1'b0;
    cyc(8);
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_straps;
    logic [15:0] adv_t [4] = '{16'h0061, 16'h0181, 16'h00a1, 16'h01e1};
    logic [15:0] bmc_t [4] = '{16'h1100, 16'h3100, 16'h3000, 16'h3100};
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], i[0], i[1]);
      rd(5'h04, rv);
      chk(rv, adv_t[i]);
      chk(flp_word, adv_t[i]);
      chkb(flp_send, 1'b1);
      rd(5'h00, rv);
      chk(rv, bmc_t[i]);
      rd(5'h19, rv);
      chk(rv, {i[1], 15'h0000} | {10'h000, i[0], 5'h00});
      chkb(led_link_only, i[0]);
      rd(5'h01, rv);
      chk(rv, 16'h7849);
    end
  endtask : t_straps

  task automatic t_restart;
    int n;
    wr(5'h04, 16'h00e1);
    cyc(1);
    chk(flp_word, 16'h00e1);
    wr(5'h00, 16'h1200);
    chkb(tx_quiet, 1'b1);
    n = 0;
    while (tx_quiet === 1'b1 && n < 200) begin
      chkb(flp_send, 1'b0);
      cyc(1);
      n++;
    end
    chkb(n >= BK - 2 && n <= BK, 1'b1);
    chkb(flp_send, 1'b1);
  endtask : t_restart

  task automatic t_negotiate;
    page_word = 16'h01e1;
    page_en = 1'b1;
    wait_hi(page_rx_valid);
    sig_100 = 1'b1;
    wait_hi(an_done);
    chkb(speed_100, 1'b1);
    chkb(full_duplex, 1'b0);
    rd(5'h05, rv);
    chk(rv, 16'h01e1);
    rd(5'h01, rv);
    chk(rv, 16'h786d);
    rd(5'h06, rv);
    chk(rv & 16'h0019, 16'h0001);
    rd(5'h10, rv);
    chk(rv & 16'h0017, 16'h0011);
  endtask : t_negotiate

  // losing the negotiated link must go straight back to bursts, no hold-off
  task automatic t_link_loss;
    page_en = 1'b0;
    sig_100 = 1'b0;
    cyc(5);
    chkb(an_done, 1'b0);
    chkb(flp_send, 1'b1);
    chkb(tx_quiet, 1'b0);
  endtask : t_link_loss

  task automatic t_parallel;
    {sig_10, sig_100} = 2'h3;
    cyc(5);
    rd(5'h06, rv);
    chk(rv & 16'h0010, 16'h0010);
    chkb(an_done, 1'b0);
    sig_100 = 1'b0;
    wait_hi(an_done);
    rd(5'h05, rv);
    chk(rv, 16'h0021);
    rd(5'h06, rv);
    chk(rv & 16'h0001, 16'h0000);
    chkb(speed_100, 1'b0);
    rd(5'h10, rv);
    chk(rv & 16'h0017, 16'h0013);
  endtask : t_parallel

  task automatic t_forced;
    wr(5'h00, 16'h2100);
    cyc(2);
    chk({speed_100, full_duplex, flp_send, link_up}, 16'h000c);
    wr(5'h00, 16'h0000);
    cyc(2);
    chk({speed_100, full_duplex, link_up, crossover}, 16'h0002);
    wr(5'h19, 16'h4000);
    cyc(2);
    chkb(crossover, 1'b1);
    chkb(led_link_only, 1'b0);
    wr(5'h05, 16'hffff);
    rd(5'h05, rv);
    chk(rv, 16'h0021);
    rd(5'h1f, rv);
    chk(rv, 16'h0000);
    // no partner at all: the exchange times out and falls back to the hold-off
    sig_10 = 1'b0;
    wr(5'h00, 16'h1000);
    cyc(BK + 398);
    chkb(flp_send, 1'b1);
    cyc(4);
    chkb(tx_quiet, 1'b1);
  endtask : t_forced

  // ----------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    t_straps;
    t_restart;
    t_negotiate;
    t_link_loss;
    t_parallel;
    t_forced;
    complete_run;
  end

  // the whole sequence needs about 700 cycles; the 20000-cycle limit is over twenty times that
  initial begin
    #(20000 * 100);
    n_mismatch++;
    complete_run;
  end
endmodule : anc_autoneg_tb

`default_nettype wire

/* File: verification/anc_link_partner.sv */
// anc_link_partner: behavioural far end of the pair, seen as receiver flags and pages.
// assumes the page decoder sits on core_clk; the bench sets the partner's behaviour.
`timescale 1ns/10ps
`default_nettype none

module anc_link_partner (
  input  wire logic        core_clk,
  input  wire logic        flp_send,
  input  wire logic        page_en,
  input  wire logic [15:0] page_word,
  input  wire logic        sig_10,
  input  wire logic        sig_100,
  output logic             link_10_good,
  output logic             link_100_good,
  output var logic         page_rx_valid,
  output var logic  [15:0] page_rx_word
);
  logic [3:0] gap;
  initial begin
    gap = 4'h0;
    page_rx_valid = 1'b0;
    page_rx_word = 16'h0000;
  end
  // a page arrives only while bursts are on the line; between pages the word toggles
  always @(posedge core_clk) begin
    gap <= gap + 4'h1;
    page_rx_valid <= flp_send && page_en && (gap == 4'hf);
    page_rx_word <= (flp_send && page_en && gap == 4'hf) ? page_word : ~page_rx_word;
  end
  assign link_10_good  = sig_10;
  assign link_100_good = sig_100;
endmodule : anc_link_partner

`default_nettype wire
